/* File: include/clk_bank_consts.vh */
// Constants for the clock bank divider, freeze and sync block.
// Assumes inclusion by bare name from design files on a single clk domain.
`ifndef CLK_BANK_CONSTS_VH
`define CLK_BANK_CONSTS_VH
`define FRZ_BITS        12
`define FRZ_CNT_W       4
`define FRZ_RESET       12'h0fff
`define FRZ_A_LSB       0
`define FRZ_B_LSB       4
`define FRZ_C_LSB       8
`define FRZ_SYNC_BIT    11
`define DIV_W           5
`define HALF_RATIO      5'h02
// Common phase counter: 240 cycles, a multiple of every ratio
`define ALIGN_LOAD      8'hee
`define ALIGN_WRAP      8'hef
`endif

/* File: hw/half_div.v */
// Divide-by-N clock generator on the VCO clock, N even, taken at a period boundary.
// Assumes ratio is even and at least two; ratio loads at a period boundary.
`timescale 1ns/1ps
`include "clk_bank_consts.vh"
module half_div (
    input  wire              clk,
    input  wire              rst_n,
    input  wire [`DIV_W-1:0] ratio,
    output reg               q_r,
    output wire              rise_next,
    output wire              fall_next
);
    reg [`DIV_W-1:0] cnt_r;
    reg [`DIV_W-1:0] ratio_r;
    wire [`DIV_W-1:0] half = {1'b0, ratio_r[`DIV_W-1:1]};

    assign rise_next = (cnt_r == ratio_r - 5'h01);
    assign fall_next = (cnt_r == half - 5'h01);

    always @(posedge clk) begin
        if (!rst_n) begin
            cnt_r   <= 5'h00;
            ratio_r <= `HALF_RATIO;
            q_r     <= 1'b0;
        end else if (rise_next) begin
            // New ratio only at a period boundary
            cnt_r   <= 5'h00;
            ratio_r <= ratio;
            q_r     <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 5'h01;
            if (fall_next)
                q_r <= 1'b0;
        end
    end
endmodule // half_div

/* File: hw/clk_bank.v */
// Bank dividers, sync pulse and serial freeze register of the clock buffer.
// Assumes clk is the VCO clock; select pins static relative to clk or slow.
`timescale 1ns/1ps
`include "clk_bank_consts.vh"
module clk_bank (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        vco_halving_select,
    input  wire [1:0]  bank_a_divide_select,
    input  wire [1:0]  bank_b_divide_select,
    input  wire [1:0]  bank_c_divide_select,
    input  wire        bank_c_invert_control,
    input  wire        serial_clock,
    input  wire        serial_freeze_data,
    output reg  [3:0]  bank_a_outputs,
    output reg  [3:0]  bank_b_outputs,
    output reg  [3:0]  bank_c_outputs,
    output reg         sync_output,
    output wire        outputs_enable
);
    // ****************************************
    // Input synchronisers
    // ****************************************
    reg [2:0] sclk_s;
    reg [2:0] sdat_s;
    reg [2:0] vsel_s;
    reg [2:0] asel_s0, asel_s1, bsel_s0, bsel_s1, csel_s0, csel_s1, inv_s;

    always @(posedge clk) begin
        if (!rst_n) begin
            sclk_s  <= 3'h0;
            sdat_s  <= 3'h7;
            vsel_s  <= 3'h0;
            asel_s0 <= 3'h0;
            asel_s1 <= 3'h0;
            bsel_s0 <= 3'h0;
            bsel_s1 <= 3'h0;
            csel_s0 <= 3'h0;
            csel_s1 <= 3'h0;
            inv_s   <= 3'h0;
        end else begin
            sclk_s  <= {sclk_s[1:0], serial_clock};
            sdat_s  <= {sdat_s[1:0], serial_freeze_data};
            vsel_s  <= {vsel_s[1:0], vco_halving_select};
            asel_s0 <= {asel_s0[1:0], bank_a_divide_select[0]};
            asel_s1 <= {asel_s1[1:0], bank_a_divide_select[1]};
            bsel_s0 <= {bsel_s0[1:0], bank_b_divide_select[0]};
            bsel_s1 <= {bsel_s1[1:0], bank_b_divide_select[1]};
            csel_s0 <= {csel_s0[1:0], bank_c_divide_select[0]};
            csel_s1 <= {csel_s1[1:0], bank_c_divide_select[1]};
            inv_s   <= {inv_s[1:0], bank_c_invert_control};
        end
    end

    // Settled levels: change once second and third stages agree
    reg       vsel_r, inv_r;
    reg [1:0] asel_r, bsel_r, csel_r;
    always @(posedge clk) begin
        if (!rst_n) begin
            vsel_r <= 1'b0;
            inv_r  <= 1'b0;
            asel_r <= 2'h0;
            bsel_r <= 2'h0;
            csel_r <= 2'h0;
        end else begin
            if (vsel_s[2] == vsel_s[1])
                vsel_r <= vsel_s[2];
            if (inv_s[2] == inv_s[1])
                inv_r <= inv_s[2];
            if ((asel_s0[2] == asel_s0[1]) && (asel_s1[2] == asel_s1[1]))
                asel_r <= {asel_s1[2], asel_s0[2]};
            if ((bsel_s0[2] == bsel_s0[1]) && (bsel_s1[2] == bsel_s1[1]))
                bsel_r <= {bsel_s1[2], bsel_s0[2]};
            if ((csel_s0[2] == csel_s0[1]) && (csel_s1[2] == csel_s1[1]))
                csel_r <= {csel_s1[2], csel_s0[2]};
        end
    end

    // ****************************************
    // Ratio tables
    // ****************************************
    // Ratios in VCO cycles; halving low doubles them
    reg [`DIV_W-1:0] ra, rb, rc;
    always @* begin
        case (asel_r)
            2'h0:    ra = 5'h04;
            2'h1:    ra = 5'h06;
            2'h2:    ra = 5'h08;
            default: ra = 5'h0c;
        endcase
        case (bsel_r)
            2'h0:    rb = 5'h04;
            2'h1:    rb = 5'h06;
            2'h2:    rb = 5'h08;
            default: rb = 5'h0a;
        endcase
        case (csel_r)
            2'h0:    rc = 5'h02;
            2'h1:    rc = 5'h04;
            2'h2:    rc = 5'h06;
            default: rc = 5'h08;
        endcase
        if (!vsel_r) begin
            ra = {ra[`DIV_W-2:0], 1'b0};
            rb = {rb[`DIV_W-2:0], 1'b0};
            rc = {rc[`DIV_W-2:0], 1'b0};
        end
    end

    // ****************************************
    // Bank dividers
    // ****************************************
    // Common phase counter: every ratio divides its length, so all
    // banks share a rising edge at its wrap; new ratios load only there
    reg [7:0]        align_r;
    reg [`DIV_W-1:0] ra_cur_r, rb_cur_r, rc_cur_r;
    reg [`DIV_W-1:0] ra_use_r, rc_use_r;
    always @(posedge clk) begin
        if (!rst_n) begin
            align_r  <= `ALIGN_LOAD;
            ra_cur_r <= `HALF_RATIO;
            rb_cur_r <= `HALF_RATIO;
            rc_cur_r <= `HALF_RATIO;
        end else begin
            align_r <= (align_r == `ALIGN_WRAP) ? 8'h00 : align_r + 8'h01;
            if (align_r == `ALIGN_LOAD) begin
                ra_cur_r <= ra;
                rb_cur_r <= rb;
                rc_cur_r <= rc;
            end
        end
    end

    wire qa, qb, qc, a_rise, c_rise;
    half_div u_div_a (
        .clk       (clk),
        .rst_n     (rst_n),
        .ratio     (ra_cur_r),
        .q_r       (qa),
        .rise_next (a_rise),
        .fall_next ()
    );
    half_div u_div_b (
        .clk       (clk),
        .rst_n     (rst_n),
        .ratio     (rb_cur_r),
        .q_r       (qb),
        .rise_next (),
        .fall_next ()
    );
    half_div u_div_c (
        .clk       (clk),
        .rst_n     (rst_n),
        .ratio     (rc_cur_r),
        .q_r       (qc),
        .rise_next (c_rise),
        .fall_next ()
    );

    // Ratio dividers A and C are running, for the sync predictor
    always @(posedge clk) begin
        if (!rst_n) begin
            ra_use_r <= `HALF_RATIO;
            rc_use_r <= `HALF_RATIO;
        end else begin
            if (a_rise)
                ra_use_r <= ra_cur_r;
            if (c_rise)
                rc_use_r <= rc_cur_r;
        end
    end

    // ****************************************
    // Sync pulse
    // ****************************************
    // Phase counters of banks A and C predict coincident rising edges
    reg [7:0] ph_a_r, ph_c_r;
    wire [`DIV_W-1:0] fast = (ra_use_r < rc_use_r) ? ra_use_r : rc_use_r;
    wire [7:0] ra8 = {3'h0, ra_use_r};
    wire [7:0] rc8 = {3'h0, rc_use_r};
    wire [7:0] f8  = {3'h0, fast};
    // Cycles until next rising edge of banks A and C
    wire [7:0] to_a = ra8 - ph_a_r;
    wire [7:0] to_c = rc8 - ph_c_r;
    reg  [7:0] lcm_left;
    reg  [7:0] sync_cnt_r;
    reg        sync_low_r;

    always @(posedge clk) begin
        if (!rst_n) begin
            ph_a_r <= 8'h00;
            ph_c_r <= 8'h00;
        end else begin
            ph_a_r <= a_rise ? 8'h00 : ph_a_r + 8'h01;
            ph_c_r <= c_rise ? 8'h00 : ph_c_r + 8'h01;
        end
    end

    // Time to next coincidence found by stepping the earlier edge
    integer k;
    reg [7:0] ta, tc;
    always @* begin
        ta = to_a;
        tc = to_c;
        for (k = 0; k < 16; k = k + 1) begin
            if (ta < tc)
                ta = ta + ra8;
            else if (tc < ta)
                tc = tc + rc8;
        end
        lcm_left = ta;
    end

    // Equal ratios: every edge coincides, so mark every other one
    wire same_ratio = (ra_use_r == rc_use_r);
    wire sync_arm   = same_ratio ? (lcm_left == 8'h01) : (lcm_left == f8 + 8'h01);

    always @(posedge clk) begin
        if (!rst_n) begin
            sync_low_r <= 1'b0;
            sync_cnt_r <= 8'h00;
        end else if (sync_low_r) begin
            sync_cnt_r <= sync_cnt_r - 8'h01;
            if (sync_cnt_r == 8'h01)
                sync_low_r <= 1'b0;
        end else if (sync_arm) begin
            sync_low_r <= 1'b1;
            sync_cnt_r <= f8;
        end
    end

    // ****************************************
    // Serial freeze register
    // ****************************************
    localparam S_IDLE = 2'b01;
    localparam S_SHIFT = 2'b10;
    reg [1:0]            st_r;
    reg [`FRZ_BITS-1:0]  sh_r;
    reg [`FRZ_BITS-1:0]  frz_r;
    reg [`FRZ_CNT_W-1:0] bit_r;
    reg                  sclk_lvl_r;
    wire sclk_rise = (sclk_s[2] == sclk_s[1]) && sclk_s[2] && !sclk_lvl_r;

    always @(posedge clk) begin
        if (!rst_n) begin
            st_r       <= S_IDLE;
            sh_r       <= `FRZ_RESET;
            frz_r      <= `FRZ_RESET;
            bit_r      <= 4'h0;
            sclk_lvl_r <= 1'b0;
        end else begin
            if (sclk_s[2] == sclk_s[1])
                sclk_lvl_r <= sclk_s[2];
            if (sclk_rise) begin
                case (st_r)
                    S_IDLE: begin
                        if (!sdat_s[2]) begin
                            st_r  <= S_SHIFT;
                            bit_r <= 4'h0;
                        end
                    end
                    S_SHIFT: begin
                        // Bit 0 arrives first, shifts down to lsb
                        sh_r  <= {sdat_s[2], sh_r[`FRZ_BITS-1:1]};
                        bit_r <= bit_r + 4'h1;
                        if (bit_r == 4'hb) begin
                            frz_r <= {sdat_s[2], sh_r[`FRZ_BITS-1:1]};
                            st_r  <= S_IDLE;
                        end
                    end
                    default: st_r <= S_IDLE;
                endcase
            end
        end
    end

    // ****************************************
    // Output gating
    // ****************************************
    // Enables update only while their output is low: no runt pulses
    reg [3:0] en_a_r, en_b_r;
    reg [2:0] en_c_r;
    reg       en_s_r;
    reg       inv_q;
    always @(posedge clk) begin
        if (!rst_n) begin
            en_a_r <= 4'hf;
            en_b_r <= 4'hf;
            en_c_r <= 3'h7;
            en_s_r <= 1'b1;
        end else begin
            if (!qa)
                en_a_r <= frz_r[`FRZ_A_LSB+3:`FRZ_A_LSB];
            if (!qb)
                en_b_r <= frz_r[`FRZ_B_LSB+3:`FRZ_B_LSB];
            if (!qc)
                en_c_r[0] <= frz_r[`FRZ_C_LSB];
            // Outputs 2 and 3 are low when bank C equals the invert state
            if (qc == inv_q)
                en_c_r[2:1] <= frz_r[`FRZ_C_LSB+2:`FRZ_C_LSB+1];
            // Sync output is low inside its pulse, so change only there
            if (sync_low_r)
                en_s_r <= frz_r[`FRZ_SYNC_BIT];
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            bank_a_outputs <= 4'h0;
            bank_b_outputs <= 4'h0;
            bank_c_outputs <= 4'h0;
            sync_output    <= 1'b0;
            inv_q          <= 1'b0;
        end else begin
            // Inversion follows only while bank C is low
            if (!qc)
                inv_q <= inv_r;
            bank_a_outputs <= {4{qa}} & en_a_r;
            bank_b_outputs <= {4{qb}} & en_b_r;
            bank_c_outputs[0] <= qc;
            bank_c_outputs[1] <= qc & en_c_r[0];
            bank_c_outputs[2] <= (qc ^ inv_q) & en_c_r[1];
            bank_c_outputs[3] <= (qc ^ inv_q) & en_c_r[2];
            sync_output    <= en_s_r ? !sync_low_r : 1'b0;
        end
    end

    assign outputs_enable = rst_n;
endmodule // clk_bank

/* File: tb/freeze_ctl.sv */
// Model of the serial freeze controller: free-running shift clock, framed data.
// Assumes the device samples data on the shift clock rising edge.
`timescale 1ns/1ps
module freeze_ctl (
    output logic sclk,
    output logic sdat
);
    initial begin
        sclk = 1'b0;
        sdat = 1'b1;
    end
    always #40 sclk = ~sclk;
    task automatic send(input logic [11:0] v);
        int i;
        @(negedge sclk) sdat = 1'b0;
        for (i = 0; i < 12; i++) @(negedge sclk) sdat = v[i];
        @(negedge sclk) sdat = 1'b1;
    endtask
endmodule // freeze_ctl

/* File: tb/clk_bank_sva.sv */
// Port checker for clk_bank.
// Assumes one clk domain; bound to every clk_bank instance.
`timescale 1ns/1ps
module clk_bank_sva (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       bank_c_invert_control,
    input wire logic [3:0] bank_a_outputs,
    input wire logic [3:0] bank_b_outputs,
    input wire logic [3:0] bank_c_outputs,
    input wire logic       sync_output,
    input wire logic       outputs_enable
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [4:0] c0_hold_r;
    // Cycles since bank C output 0 last changed
    always @(posedge clk)
        if (!rst_n || $changed(bank_c_outputs[0])) c0_hold_r <= 5'h00;
        else if (c0_hold_r != 5'h1f) c0_hold_r <= c0_hold_r + 5'h01;
    property p_outen; disable iff (1'b0) outputs_enable == rst_n; endproperty
    a_outen: assert property (p_outen) else $error("enable differs from reset");
    property p_rst_low;
        disable iff (1'b0) !rst_n |=>
            {bank_a_outputs, bank_b_outputs, bank_c_outputs, sync_output} == 13'h0000;
    endproperty
    a_rst_low: assert property (p_rst_low) else $error("outputs live in reset");
    property p_c0_runs; c0_hold_r < 5'h10; endproperty
    a_c0_runs: assert property (p_c0_runs) else $error("bank C output 0 stopped");
    property p_a_min; $rose(bank_a_outputs[0]) |=> bank_a_outputs[0]; endproperty
    a_a_min: assert property (p_a_min) else $error("short high on bank A");
    property p_b_min; $fell(bank_b_outputs[0]) |=> !bank_b_outputs[0]; endproperty
    a_b_min: assert property (p_b_min) else $error("short low on bank B");
    property p_a_max; $rose(bank_a_outputs[0]) |-> ##[2:12] !bank_a_outputs[0]; endproperty
    a_a_max: assert property (p_a_max) else $error("long high on bank A");
    property p_b_max; $rose(bank_b_outputs[0]) |-> ##[2:10] !bank_b_outputs[0]; endproperty
    a_b_max: assert property (p_b_max) else $error("long high on bank B");
    property p_c_max; $rose(bank_c_outputs[0]) |-> ##[1:8] !bank_c_outputs[0]; endproperty
    a_c_max: assert property (p_c_max) else $error("long high on bank C");
    c_sync: cover property ($fell(sync_output));
    c_inv: cover property (bank_c_invert_control && $rose(bank_c_outputs[3]));
    c_b3: cover property ($rose(bank_b_outputs[3]));
endmodule // clk_bank_sva
bind clk_bank clk_bank_sva i_sva (.clk(clk), .rst_n(rst_n),
    .bank_c_invert_control(bank_c_invert_control), .bank_a_outputs(bank_a_outputs),
    .bank_b_outputs(bank_b_outputs), .bank_c_outputs(bank_c_outputs),
    .sync_output(sync_output), .outputs_enable(outputs_enable));

/* File: tb/test_clk_bank.sv */
// Self-checking bench for clk_bank with a serial freeze controller model.
// Assumes freeze_ctl and the bound checker are compiled first.
`timescale 1ns/1ps
module test_clk_bank;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        halve = 1'b1;
    logic [1:0]  sel_a = 2'h0;
    logic [1:0]  sel_b = 2'h0;
    logic [1:0]  sel_c = 2'h0;
    logic        inv = 1'b0;
    wire         sclk;
    wire         sdat;
    wire  [3:0]  qa;
    wire  [3:0]  qb;
    wire  [3:0]  qc;
    wire         sync;
    wire         oe;
    logic [31:0] lfsr_r = 32'h30d0_37ee;
    int          miscompares = 0;
    int          n_checks = 0;
    int          cycles = 0;
    int          ta[4] = '{8, 12, 16, 24};
    int          tb[4] = '{8, 12, 16, 20};
    int          tc[4] = '{4, 8, 12, 16};
    int          i;
    int          n;
    int          pa;
    int          pc;
    logic [11:0] v;
    logic [11:0] hi;
    logic        c0_seen;
    always #2.5 clk = ~clk;
    clk_bank i_dut (.clk(clk), .rst_n(rst_n), .vco_halving_select(halve),
        .bank_a_divide_select(sel_a), .bank_b_divide_select(sel_b),
        .bank_c_divide_select(sel_c), .bank_c_invert_control(inv), .serial_clock(sclk),
        .serial_freeze_data(sdat), .bank_a_outputs(qa), .bank_b_outputs(qb),
        .bank_c_outputs(qc), .sync_output(sync), .outputs_enable(oe));
    freeze_ctl i_ctl (.sclk(sclk), .sdat(sdat));
    function automatic logic [31:0] lfsr_step(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic pick(input int s);
        case (s)
            0: return qa[0];
            1: return qb[0];
            2: return qc[0];
            default: return sync;
        endcase
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        if (miscompares == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Counts negedges until the picked level is seen
    task automatic wait_lvl(input int s, input logic lv, inout int cnt);
        int k;
        for (k = 0; k < 300 && pick(s) !== lv; k++) begin
            @(negedge clk);
            cnt = cnt + 1;
        end
    endtask
    task automatic period(input int s, output int p);
        int m;
        m = 0;
        @(negedge clk);
        wait_lvl(s, 1'b0, m);
        wait_lvl(s, 1'b1, m);
        p = 0;
        wait_lvl(s, 1'b0, p);
        wait_lvl(s, 1'b1, p);
    endtask
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 60000) begin
            miscompares = miscompares + 1;
            complete_run;
        end
    end
    // ************************************
    // Main sequence
    // ************************************
    initial begin
        repeat (2) @(posedge clk);
        @(negedge clk);
        check({2'h0, oe, qa, qb, qc, sync}, 16'h0000);
        @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 8; i++) begin
            lfsr_r = lfsr_step(lfsr_r);
            @(posedge clk);
            halve <= i[2];
            sel_a <= i[1:0];
            sel_b <= lfsr_r[1:0];
            sel_c <= i[1:0];
            // New ratios wait for the common phase wrap, up to 240 cycles
            repeat (300) @(posedge clk);
            period(0, n);
            check(16'(n), 16'(ta[i % 4] >> i[2]));
            period(1, n);
            check(16'(n), 16'(tb[lfsr_r[1:0]] >> i[2]));
            period(2, n);
            check(16'(n), 16'(tc[i % 4] >> i[2]));
        end
        for (i = 0; i < 32; i++) begin
            lfsr_r = lfsr_step(lfsr_r);
            @(posedge clk);
            halve <= i[4];
            sel_a <= i[3:2];
            sel_c <= i[1:0];
            inv <= lfsr_r[5];
            repeat (300) @(posedge clk);
            pa = ta[i[3:2]] >> i[4];
            pc = tc[i[1:0]] >> i[4];
            n = 0;
            @(negedge clk);
            wait_lvl(3, 1'b1, n);
            wait_lvl(3, 1'b0, n);
            n = 0;
            wait_lvl(3, 1'b1, n);
            check(16'(n), 16'(pa < pc ? pa : pc));
            check({14'h0, qa[0], qc[0]}, 16'h0003);
            check({14'h0, qc[3] ^ qc[1], qc[2] ^ qc[1]}, {14'h0, inv, inv});
        end
        for (i = 0; i < 4; i++) begin
            lfsr_r = lfsr_step(lfsr_r);
            v = (i == 3) ? 12'hfff : lfsr_r[11:0];
            i_ctl.send(v);
            repeat (200) @(posedge clk);
            hi = 12'h000;
            c0_seen = 1'b0;
            repeat (60) begin
                @(negedge clk);
                hi = hi | {sync, qc[3:1], qb, qa};
                c0_seen = c0_seen | qc[0];
            end
            check({4'h0, hi}, {4'h0, v});
            check({15'h0, c0_seen}, 16'h0001);
        end
        complete_run;
    end
endmodule // test_clk_bank
